// [verilog/rivp_vector_unit.sv]
// Summary of operation
// RULE_01: With the boot reset fuse unprogrammed every reset starts fetching at word 0x000.
// RULE_02: Vectors 2 to 11 sit at words 0x001 to 0x00A, from external request 0 up to SPI done.
// RULE_03: Vectors 12 to 21 sit at words 0x00B to 0x014, from USART receive up to store ready.
// RULE_04: With the boot reset fuse programmed reset starts at the boot loader reset address.
// RULE_05: With the table select bit set each vector address is its base address plus the boot start.
// RULE_06: Vectors start at 0x0001 with select clear and at boot reset address plus 0x0001 with it set.
// RULE_07: A fuse value of 1 means unprogrammed (reset at zero) and 0 means programmed (boot reset).
// RULE_08: A vector is fetched only for a source that is enabled and taken.
// RULE_09: When reset and vectors lie in different sections the other section's slots are never used.
// RULE_10: The table select bit is bit 1 of the control register, resets to zero, one means boot section.
// RULE_11: Software arms unlock, then within four cycles writes select with unlock zero; unlock self clears.
// RULE_12: Interrupts are held off from the arming cycle until after the next instruction, or four cycles.
// RULE_13: Among several pending requests the lowest vector number is served.
`timescale 1ns/10ps
`default_nettype none

`include "rivp_defs.svh"

module rivp_vector_unit (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      resetn,
    // fuse straps
    input  wire logic                      boot_reset_select_fuse,
    input  wire rivp_pkg::rivp_addr_t      boot_reset_addr,
    // general_interrupt_control write from the core and read back
    input  wire logic                      gic_wr,
    input  wire rivp_pkg::rivp_gic_t       gic_wdata,
    output rivp_pkg::rivp_gic_t            gic_rdata,
    // core status
    input  wire logic                      instr_done,
    input  wire logic                      global_int_enable,
    // interrupt requests and acceptance
    input  wire logic [`RIVP_NUM_IRQ-1:0]  irq_req,
    input  wire logic                      irq_ack,
    output logic                           irq_valid,
    output rivp_pkg::rivp_addr_t           irq_vec_addr,
    output logic [`RIVP_NUM_W-1:0]         irq_vec_num,
    output logic                           irq_blocked,
    // reset entry
    output logic                           reset_vec_valid,
    output rivp_pkg::rivp_addr_t           reset_vec_addr
);

    // ****************************************************************
    // state
    // ****************************************************************
    rivp_pkg::rivp_state_t st_reg;
    rivp_pkg::rivp_state_t st_next;

    logic                      pick_any;
    logic [`RIVP_NUM_W-1:0]    pick_num;
    rivp_pkg::rivp_addr_t      pick_addr;
    logic                      arm_wr;
    logic                      sel_wr;

    // ****************************************************************
    // priority pick
    // ****************************************************************
    rivp_vec_pick u_pick (
        .req       (irq_req),
        .sel       (st_reg.sel),
        .boot_addr (boot_reset_addr),
        .any       (pick_any),
        .num       (pick_num),
        .addr      (pick_addr)
    );

    // decoded control writes
    assign arm_wr = gic_wr & gic_wdata.vector_change_unlock;
    assign sel_wr = gic_wr & ~gic_wdata.vector_change_unlock & (st_reg.phase == rivp_pkg::RIVP_ARMED);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        // unlock window and post-write hold
        unique case (st_reg.phase)
            rivp_pkg::RIVP_IDLE: begin
                st_next.phase = rivp_pkg::RIVP_IDLE;
            end
            rivp_pkg::RIVP_ARMED: begin
                if (st_reg.cnt == 2'h0) begin
                    st_next.phase = rivp_pkg::RIVP_IDLE;          // [RULE_11]
                end else begin
                    st_next.cnt = st_reg.cnt - 2'h1;
                end
            end
            rivp_pkg::RIVP_HOLD: begin
                // the instruction after the select write has retired
                if (instr_done) begin
                    st_next.phase = rivp_pkg::RIVP_IDLE;          // [RULE_12]
                end
            end
            default: begin
                st_next.phase = rivp_pkg::RIVP_IDLE;
            end
        endcase
        // writes override the countdown; re-arming restarts the window
        if (arm_wr) begin
            st_next.phase = rivp_pkg::RIVP_ARMED;                 // [RULE_11]
            st_next.cnt   = `RIVP_UNLOCK_LOAD;
        end else if (sel_wr) begin
            st_next.sel   = gic_wdata.vector_table_select;       // [RULE_10] [RULE_11]
            st_next.phase = rivp_pkg::RIVP_HOLD;                  // [RULE_12]
        end
        // fuse sampled once, on the first edge after reset release
        if (!st_reg.rst.valid) begin
            st_next.rst.valid = 1'b1;
            st_next.rst.num   = `RIVP_RESET_VEC_NUM;
            st_next.rst.addr  = (boot_reset_select_fuse == `RIVP_FUSE_UNPROG)
                              ? `RIVP_RESET_ADDR                  // [RULE_01] [RULE_07]
                              : boot_reset_addr;                  // [RULE_04]
        end
        // acceptance drops the stale pick so a source is never taken twice
        st_next.irq.valid = pick_any & ~irq_ack;                  // [RULE_08]
        st_next.irq.num   = pick_num;                             // [RULE_13]
        st_next.irq.addr  = pick_addr;                            // [RULE_09]
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg       <= '0;
            st_reg.phase <= rivp_pkg::RIVP_IDLE;
            st_reg.sel   <= `RIVP_SEL_RESET;                      // [RULE_10]
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // block covers the arming cycle itself, not only the armed state
    assign irq_blocked = arm_wr | (st_reg.phase != rivp_pkg::RIVP_IDLE);          // [RULE_12]
    assign irq_valid   = st_reg.irq.valid & global_int_enable & st_reg.rst.valid
                       & ~irq_blocked;                                            // [RULE_08]
    assign irq_vec_addr    = st_reg.irq.addr;
    assign irq_vec_num     = st_reg.irq.num;
    assign reset_vec_valid = st_reg.rst.valid;
    assign reset_vec_addr  = st_reg.rst.addr;
    assign gic_rdata = {st_reg.sel, (st_reg.phase == rivp_pkg::RIVP_ARMED)};  // select in bit 1, armed in bit 0

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // helper: requests seen by the pick one cycle back
    logic [`RIVP_NUM_IRQ-1:0] chk_req_reg;
    logic [`RIVP_NUM_W-1:0]   chk_idx;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chk_req_reg <= '0;
        end else begin
            chk_req_reg <= irq_req;
        end
    end
    assign chk_idx = irq_vec_num - `RIVP_FIRST_IRQ_VEC;

    property p_reset_zero;
        $rose(reset_vec_valid) && $past(boot_reset_select_fuse) |-> reset_vec_addr == `RIVP_RESET_ADDR;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset entry not at zero"); // [RULE_01] [RULE_07]

    property p_reset_boot;
        $rose(reset_vec_valid) && !$past(boot_reset_select_fuse) |-> reset_vec_addr == $past(boot_reset_addr);
    endproperty
    a_reset_boot: assert property (p_reset_boot) else $error("reset entry not at boot address"); // [RULE_04]

    property p_table_low;
        irq_valid && !gic_rdata.vector_table_select
            |-> irq_vec_addr == `RIVP_IRQ_BASE + `RIVP_PC_W'(chk_idx);
    endproperty
    a_table_low: assert property (p_table_low) else $error("vector address wrong in low table"); // [RULE_02] [RULE_03] [RULE_06]

    property p_table_boot;
        irq_valid && gic_rdata.vector_table_select
            |-> irq_vec_addr == boot_reset_addr + `RIVP_IRQ_BASE + `RIVP_PC_W'(chk_idx);
    endproperty
    a_table_boot: assert property (p_table_boot) else $error("relocated vector address wrong"); // [RULE_05] [RULE_06]

    property p_not_reset_slot;
        irq_valid |-> irq_vec_addr != reset_vec_addr;
    endproperty
    a_not_reset_slot: assert property (p_not_reset_slot) else $error("vector overlaps reset entry"); // [RULE_09]

    property p_sel_reset;
        $rose(reset_vec_valid) |-> !gic_rdata.vector_table_select;
    endproperty
    a_sel_reset: assert property (p_sel_reset) else $error("select bit not zero after reset"); // [RULE_10]

    property p_unlock_expires;
        $rose(gic_rdata.vector_change_unlock) ##0 (!gic_wr)[*4] |=> !gic_rdata.vector_change_unlock;
    endproperty
    a_unlock_expires: assert property (p_unlock_expires) else $error("unlock outlived four cycles"); // [RULE_11]

    property p_unlock_holds;
        arm_wr ##1 (!gic_wr)[*3] |-> gic_rdata.vector_change_unlock;
    endproperty
    a_unlock_holds: assert property (p_unlock_holds) else $error("unlock dropped early"); // [RULE_11]

    property p_sel_locked;
        gic_wr && !sel_wr |=> $stable(gic_rdata.vector_table_select);
    endproperty
    a_sel_locked: assert property (p_sel_locked) else $error("select changed without unlock"); // [RULE_11]

    property p_sel_taken;
        sel_wr |=> gic_rdata.vector_table_select == $past(gic_wdata.vector_table_select)
                   && !gic_rdata.vector_change_unlock;
    endproperty
    a_sel_taken: assert property (p_sel_taken) else $error("select write not taken"); // [RULE_11]

    property p_block_seq;
        arm_wr |-> !irq_valid ##1 (!irq_valid)[*4];
    endproperty
    a_block_seq: assert property (p_block_seq) else $error("interrupt during unlock window"); // [RULE_12]

    property p_block_after_sel;
        sel_wr |=> !irq_valid ##1 ($past(instr_done) || !irq_valid);
    endproperty
    a_block_after_sel: assert property (p_block_after_sel) else $error("interrupt before next instruction"); // [RULE_12]

    property p_taken_only;
        irq_valid |-> global_int_enable && chk_req_reg[chk_idx];
    endproperty
    a_taken_only: assert property (p_taken_only) else $error("vector offered without request"); // [RULE_08]

    property p_lowest;
        irq_valid |-> (chk_req_reg & ((20'h0_0001 << chk_idx) - 20'h0_0001)) == 20'h0_0000;
    endproperty
    a_lowest: assert property (p_lowest) else $error("lower vector was pending"); // [RULE_13]

    property p_ack_drops;
        irq_ack |=> !irq_valid;
    endproperty
    a_ack_drops: assert property (p_ack_drops) else $error("same vector offered twice"); // [RULE_08]

    // main scenarios
    c_take_low:   cover property (irq_valid && irq_ack && !gic_rdata.vector_table_select);
    c_take_boot:  cover property (irq_valid && irq_ack && gic_rdata.vector_table_select);
    c_move:       cover property (arm_wr ##[1:4] sel_wr ##[1:8] irq_valid);
    c_timeout:    cover property (arm_wr ##1 (!gic_wr)[*4] ##1 !gic_rdata.vector_change_unlock);

endmodule : rivp_vector_unit

`default_nettype wire

// [inc/rivp_defs.svh]
`ifndef RIVP_DEFS_SVH
`define RIVP_DEFS_SVH

// ****************************************************************
// widths and counts
// ****************************************************************
`define RIVP_PC_W           12
`define RIVP_NUM_IRQ        20
`define RIVP_NUM_W          5

// ****************************************************************
// addresses and encodings
// ****************************************************************
`define RIVP_RESET_ADDR     12'h000
`define RIVP_IRQ_BASE       12'h001
`define RIVP_RESET_VEC_NUM  5'h01
`define RIVP_FIRST_IRQ_VEC  5'h02
`define RIVP_FUSE_UNPROG    1'b1
`define RIVP_SEL_RESET      1'b0
`define RIVP_SEL_BIT        1
`define RIVP_UNLOCK_BIT     0

// ****************************************************************
// timing: the unlock bit stays armed for four core cycles
// ****************************************************************
`define RIVP_UNLOCK_CYCLES  4
`define RIVP_UNLOCK_LOAD    2'(`RIVP_UNLOCK_CYCLES - 1)

`endif

// [inc/rivp_pkg.sv]
`include "rivp_defs.svh"

package rivp_pkg;

    // word address into program flash
    typedef logic [`RIVP_PC_W-1:0] rivp_addr_t;

    // write data of the general_interrupt_control bits kept here
    typedef struct packed {
        logic vector_table_select;   // bit 1
        logic vector_change_unlock;  // bit 0
    } rivp_gic_t;

    // phases of the vector move sequence
    typedef enum logic [1:0] {
        RIVP_IDLE  = 2'b00,
        RIVP_ARMED = 2'b01,
        RIVP_HOLD  = 2'b10
    } rivp_phase_t;

    // one vector handed to the core
    typedef struct packed {
        rivp_addr_t                addr;
        logic [`RIVP_NUM_W-1:0]    num;
        logic                      valid;
    } rivp_vec_t;

    // complete state of the top module
    typedef struct packed {
        rivp_phase_t phase;
        logic [1:0]  cnt;
        logic        sel;
        rivp_vec_t   rst;
        rivp_vec_t   irq;
    } rivp_state_t;

    // vector address of interrupt source idx, relocated when sel is set
    function automatic rivp_addr_t rivp_vec_addr(input logic [`RIVP_NUM_W-1:0] idx,
                                                 input logic sel,
                                                 input rivp_addr_t boot);
        rivp_addr_t base;
        base = `RIVP_IRQ_BASE + rivp_addr_t'(idx);
        return sel ? base + boot : base;
    endfunction : rivp_vec_addr

endpackage : rivp_pkg

// [verilog/rivp_vec_pick.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rivp_defs.svh"

// ****************************************************************
// lowest numbered request wins, address relocated by select bit
// ****************************************************************
module rivp_vec_pick (
    // requests, already gated by each source's own enable
    input  wire logic [`RIVP_NUM_IRQ-1:0]  req,
    // placement
    input  wire logic                      sel,
    input  wire rivp_pkg::rivp_addr_t      boot_addr,
    // winner
    output logic                           any,
    output logic [`RIVP_NUM_W-1:0]         num,
    output rivp_pkg::rivp_addr_t           addr
);

    logic [`RIVP_NUM_IRQ:0]   none_below;
    logic [`RIVP_NUM_IRQ-1:0] hit;

    // ripple of "nothing lower pending"; one hit at most
    assign none_below[0] = 1'b1;
    genvar gi;
    generate
        for (gi = 0; gi < `RIVP_NUM_IRQ; gi = gi + 1) begin : g_chain
            assign hit[gi]          = req[gi] & none_below[gi];    // [RULE_13]
            assign none_below[gi+1] = none_below[gi] & ~req[gi];
        end
    endgenerate

    // one-hot to index; vector number is index plus two
    always_comb begin
        logic [`RIVP_NUM_W-1:0] idx;
        idx = '0;
        for (int i = 0; i < `RIVP_NUM_IRQ; i++) begin
            if (hit[i]) begin
                idx = idx | `RIVP_NUM_W'(i);
            end
        end
        any  = ~none_below[`RIVP_NUM_IRQ];
        num  = idx + `RIVP_FIRST_IRQ_VEC;                           // [RULE_02] [RULE_03]
        addr = rivp_pkg::rivp_vec_addr(idx, sel, boot_addr);       // [RULE_05] [RULE_06]
    end

endmodule : rivp_vec_pick

`default_nettype wire

// [verif/rivp_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rivp_defs.svh"

// ****************************************************************
// core fetch side: takes an offered vector after a chosen delay
// ****************************************************************
module rivp_core_model (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // offer from the vector unit
    input  wire logic                     irq_valid,
    input  wire rivp_pkg::rivp_addr_t     irq_vec_addr,
    input  wire logic [`RIVP_NUM_W-1:0]   irq_vec_num,
    input  wire logic [2:0]               ack_delay,
    // acceptance and the vector fetched
    output logic                          irq_ack,
    output logic                          taken,
    output rivp_pkg::rivp_addr_t          taken_addr,
    output logic [`RIVP_NUM_W-1:0]        taken_num
);
    logic [2:0] wait_reg;

    // one ack per offer; a slow core just waits longer before the fetch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_ack    <= 1'b0;
            taken      <= 1'b0;
            taken_addr <= '0;
            taken_num  <= '0;
            wait_reg   <= 3'h0;
        end else begin
            irq_ack <= 1'b0;
            taken   <= 1'b0;
            if (irq_ack || !irq_valid) begin
                wait_reg <= 3'h0;
            end else if (wait_reg >= ack_delay) begin
                irq_ack    <= 1'b1;          // fetch only what is offered
                taken      <= 1'b1;
                taken_addr <= irq_vec_addr;
                taken_num  <= irq_vec_num;
            end else begin
                wait_reg <= wait_reg + 3'h1;
            end
        end
    end
endmodule : rivp_core_model
`default_nettype wire

// [verif/rivp_vector_unit_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rivp_defs.svh"

module rivp_vector_unit_tb;
    logic                          clk;
    logic                          resetn;
    logic                          fuse_r;
    rivp_pkg::rivp_addr_t          boot_r;
    logic                          gic_wr;
    rivp_pkg::rivp_gic_t           gic_wdata;
    rivp_pkg::rivp_gic_t           gic_rdata;
    logic                          instr_done;
    logic                          gie;
    logic [`RIVP_NUM_IRQ-1:0]      irq_req;
    logic                          irq_ack;
    logic                          irq_valid;
    rivp_pkg::rivp_addr_t          irq_vec_addr;
    logic [`RIVP_NUM_W-1:0]        irq_vec_num;
    logic                          irq_blocked;
    logic                          reset_vec_valid;
    rivp_pkg::rivp_addr_t          reset_vec_addr;
    logic [2:0]                    ack_delay;
    logic                          taken;
    rivp_pkg::rivp_addr_t          taken_addr;
    logic [`RIVP_NUM_W-1:0]        taken_num;
    logic                          cur_sel;
    logic [`RIVP_NUM_IRQ-1:0]      r;
    int                            error_cnt;
    int                            tests_run;
    int                            cyc_cnt;

    rivp_vector_unit u_dut (.clk(clk), .resetn(resetn), .boot_reset_select_fuse(fuse_r),
        .boot_reset_addr(boot_r), .gic_wr(gic_wr), .gic_wdata(gic_wdata), .gic_rdata(gic_rdata),
        .instr_done(instr_done), .global_int_enable(gie), .irq_req(irq_req), .irq_ack(irq_ack),
        .irq_valid(irq_valid), .irq_vec_addr(irq_vec_addr), .irq_vec_num(irq_vec_num),
        .irq_blocked(irq_blocked), .reset_vec_valid(reset_vec_valid), .reset_vec_addr(reset_vec_addr));

    rivp_core_model u_core (.clk(clk), .resetn(resetn), .irq_valid(irq_valid), .irq_vec_addr(irq_vec_addr),
        .irq_vec_num(irq_vec_num), .ack_delay(ack_delay), .irq_ack(irq_ack), .taken(taken),
        .taken_addr(taken_addr), .taken_num(taken_num));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // vector number of the lowest pending source
    function automatic logic [4:0] low_num(input logic [19:0] q);
        low_num = 5'h00;
        for (int i = 19; i >= 0; i--) begin
            if (q[i]) low_num = 5'(i + 2);
        end
    endfunction : low_num

    // table slot is vector number minus one, shifted by the boot start when relocated
    function automatic rivp_pkg::rivp_addr_t exp_addr(input logic [4:0] n);
        exp_addr = 12'(n) - 12'h001;
        if (cur_sel) exp_addr = exp_addr + boot_r;
    endfunction : exp_addr

    // inputs are sampled at edges, so outputs read at an edge are last cycle's settled values
    task automatic gic_write(input logic [1:0] d);
        @(posedge clk);
        gic_wr    <= 1'b1;
        gic_wdata <= rivp_pkg::rivp_gic_t'(d);
        @(posedge clk);
        gic_wr    <= 1'b0;
    endtask : gic_write

    task automatic do_reset(input logic fuse, input rivp_pkg::rivp_addr_t boot);
        resetn <= 1'b0;
        fuse_r <= fuse;
        boot_r <= boot;
        repeat (16) @(posedge clk);
        check("gic_rdata_rst", 32'(gic_rdata), 32'h0000_0000);
        resetn  <= 1'b1;
        cur_sel = 1'b0;
        repeat (2) @(posedge clk);
        check("rst_valid", 32'(reset_vec_valid), 32'h0000_0001);
        check("rst_addr", 32'(reset_vec_addr),
              32'(fuse === `RIVP_FUSE_UNPROG ? `RIVP_RESET_ADDR : boot));
    endtask : do_reset

    // offer a request set and compare what the core fetches
    task automatic serve(input logic [19:0] q);
        logic [4:0] n;
        n         = low_num(q);
        irq_req   <= q;
        ack_delay <= 3'($urandom_range(0, 4));
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            if (taken === 1'b1) break;
        end
        check("taken", 32'(taken), 32'h0000_0001);
        check("vec_num", 32'(taken_num), 32'(n));
        check("vec_addr", 32'(taken_addr), 32'(exp_addr(n)));
    endtask : serve

    // unlock, write the select bit, and watch acceptance stay held off
    task automatic move(input logic s);
        gic_write(2'b01);
        irq_req <= 20'h0_0001;
        @(posedge clk);
        check("unlock", 32'(gic_rdata.vector_change_unlock), 32'h0000_0001);
        gic_write({s, 1'b0});
        repeat (3) begin
            @(posedge clk);
            check("blocked", 32'(irq_blocked), 32'h0000_0001);
            check("no_offer", 32'(irq_valid), 32'h0000_0000);
        end
        check("select", 32'(gic_rdata.vector_table_select), 32'(s));
        check("unlock_clr", 32'(gic_rdata.vector_change_unlock), 32'h0000_0000);
        cur_sel = s;
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
        for (int k = 0; k < 3 && irq_blocked !== 1'b0; k++) @(posedge clk);
        check("unblocked", 32'(irq_blocked), 32'h0000_0000);
        serve(20'h0_0001);
        irq_req <= '0;
        repeat (3) @(posedge clk);
    endtask : move

    // ****************************************************************
    // clock, watchdog and main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // a hang is cut short well above the expected run length
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        resetn = 1'b0; fuse_r = 1'b1; boot_r = 12'hc00; gic_wr = 1'b0; gic_wdata = '0;
        instr_done = 1'b0; gie = 1'b1; irq_req = '0; ack_delay = 3'h0; cur_sel = 1'b0;
        error_cnt = 0; tests_run = 0; cyc_cnt = 0;
        void'($urandom(32'h89a9));
        do_reset(1'b1, 12'hc00);
        // every source alone, in both table placements
        for (int s = 0; s < 2; s++) begin
            if (s == 1) move(1'b1);
            for (int i = 0; i < 20; i++) serve(20'(1) << i);
            irq_req <= '0;
            repeat (3) @(posedge clk);
        end
        // random pending sets drained lowest first, back to back
        repeat (20) begin
            r = 20'($urandom);
            if (r == '0) r = 20'h8_0000;
            while (r != '0) begin
                serve(r);
                r = r & (r - 20'h0_0001);
            end
            irq_req <= '0;
            repeat (3) @(posedge clk);
        end
        // global flag low hides a pending request
        gie     <= 1'b0;
        irq_req <= 20'h8_0000;
        repeat (6) begin
            @(posedge clk);
            check("hidden", 32'(irq_valid), 32'h0000_0000);
        end
        gie <= 1'b1;
        serve(20'h8_0000);
        irq_req <= '0;
        // select write without unlock is ignored
        gic_write({~cur_sel, 1'b0});
        repeat (2) @(posedge clk);
        check("sel_kept", 32'(gic_rdata.vector_table_select), 32'(cur_sel));
        // unlock left alone clears after four cycles
        gic_write(2'b01);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            check("unlock_win", 32'(gic_rdata.vector_change_unlock), 32'h0000_0001);
            check("blk_win", 32'(irq_blocked), 32'h0000_0001);
        end
        @(posedge clk);
        check("unlock_end", 32'(gic_rdata.vector_change_unlock), 32'h0000_0000);
        check("blk_end", 32'(irq_blocked), 32'h0000_0000);
        // a select write once the window has closed is refused
        gic_write({~cur_sel, 1'b0});
        repeat (2) @(posedge clk);
        check("sel_late", 32'(gic_rdata.vector_table_select), 32'(cur_sel));
        move(1'b0);
        // programmed fuse: reset moves, vectors stay low until select is set
        do_reset(1'b0, 12'($urandom_range(12'h015, 12'hfe0)));
        serve(20'h0_0400);
        irq_req <= '0;
        repeat (3) @(posedge clk);
        move(1'b1);
        serve(20'($urandom) | 20'h8_0000);
        irq_req <= '0;
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule : rivp_vector_unit_tb
`default_nettype wire
